// ===== hdl/msd_decoder.sv
`timescale 1ns/1ps
module msd_decoder #(
  parameter int CLK_HZ = msd_pkg::CLK_HZ,
  parameter int NSI    = 64
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        frame_valid,
  input  wire logic [55:0] frame_bits,
  input  wire logic        commb_reserved,
  input  wire logic        commc_reserved,
  input  wire logic        commd_reserved,
  output logic [4:0]       uplink_format,
  output logic             sd_valid,
  output logic [15:0]      special_designator_field,
  output logic [2:0]       designator_identifier,
  output logic [3:0]       interrogator_id_subfield,
  output logic [5:0]       surveillance_identifier_subfield,
  output logic [15:0]      allcall_lockout,
  output logic [NSI-1:0]   surv_lockout,
  output logic             allcall_lock_pulse,
  output logic             surv_lock_pulse,
  output logic [1:0]       commb_multisite_command,
  output logic [2:0]       elm_multisite_command,
  output logic             commb_reserve,
  output logic             commb_close,
  output logic             commc_reserve,
  output logic             commc_close,
  output logic             commd_reserve,
  output logic             commd_close,
  output logic [3:0]       bds2_code,
  output logic [1:0]       reservation_status_query,
  output logic [5:0]       utility_message_field,
  output logic [1:0]       squitter_rate,
  output logic [1:0]       surface_antenna,
  output logic             surface_position
);
  // timer loads in seconds
  localparam logic [6:0] S60  = 7'(msd_pkg::T60_S);
  localparam logic [6:0] S120 = 7'(msd_pkg::T120_S);
  localparam logic [6:0] S15  = 7'(msd_pkg::T15_S);
  localparam int PW = $clog2(CLK_HZ);

  // frame bit n (1-based, first on air) sits at index 56-n
  function automatic logic [15:0] fld(input logic [55:0] f, input int pos,
                                      input int w);
    logic [15:0] v;
    v = '0;
    for (int i = 0; i < 16; i++)
      if (i < w)
        v[w-1-i] = f[56-pos-i];
    return v;
  endfunction

  // format and field extraction
  // size casts trim the function result, a select on a call is illegal
  wire logic [4:0]  uf_w  = 5'(fld(frame_bits, msd_pkg::UF_MSB,
                                  msd_pkg::UF_W));
  wire logic        uf_ok = (uf_w == msd_pkg::UF_SURV_ALT) ||
                            (uf_w == msd_pkg::UF_SURV_ID) ||
                            (uf_w == msd_pkg::UF_COMMA_ALT) ||
                            (uf_w == msd_pkg::UF_COMMA_ID);
  wire logic        go    = frame_valid && uf_ok;
  wire logic [2:0]  di_w  = 3'(fld(frame_bits, msd_pkg::DI_FIRST,
                                  msd_pkg::DI_W));
  wire logic [15:0] sd_w  = fld(frame_bits, msd_pkg::SD_FIRST,
                                msd_pkg::SD_W);
  wire logic [3:0]  iis_w = 4'(fld(frame_bits, msd_pkg::IIS_POS, 4));
  wire logic [5:0]  sis_w = 6'(fld(frame_bits, msd_pkg::SIS_POS, 6));
  wire logic        los_w = frame_bits[56-msd_pkg::LOS_POS];
  wire logic        lss_w = frame_bits[56-msd_pkg::LSS_POS];
  wire logic [1:0]  mbs_w = 2'(fld(frame_bits, msd_pkg::MBS_POS, 2));
  wire logic [2:0]  mes_w = 3'(fld(frame_bits, msd_pkg::MES_POS, 3));
  wire logic [2:0]  rcs_w = 3'(fld(frame_bits, msd_pkg::RCS_POS, 3));
  wire logic [3:0]  rrs_w = 4'(fld(frame_bits, msd_pkg::RRS_POS, 4));
  wire logic [1:0]  rss_w = 2'(fld(frame_bits, msd_pkg::RSS_POS, 2));
  wire logic [1:0]  sas_w = 2'(fld(frame_bits, msd_pkg::SAS_POS, 2));
  wire logic [2:0]  tcs_w = 3'(fld(frame_bits, msd_pkg::TCS_POS, 3));

  // designator gating, identifier zero blocks multisite action
  wire logic di_iis  = (di_w == msd_pkg::DI_IIS0) ||
                       (di_w == msd_pkg::DI_MULTI) ||
                       (di_w == msd_pkg::DI_RREQ);
  wire logic d_multi = go && di_w == msd_pkg::DI_MULTI;
  wire logic d_ext   = go && di_w == msd_pkg::DI_EXT;
  wire logic d_surv  = go && di_w == msd_pkg::DI_SURV;
  wire logic d_rreq  = go && di_w == msd_pkg::DI_RREQ;
  wire logic ms_ok   = d_multi && iis_w != 4'h0;
  wire logic lock_ac = (ms_ok || (d_rreq && iis_w != 4'h0)) && los_w;
  wire logic lock_sv = d_surv && lss_w && sis_w != 6'h00;

  // multisite Comm-B and ELM command decode
  wire logic mb_res = ms_ok && mbs_w == msd_pkg::MB_RES;
  wire logic mb_clo = ms_ok && mbs_w == msd_pkg::MB_CLO;
  wire logic c_res  = ms_ok && (mes_w == 3'h1 || mes_w == 3'h5);
  wire logic c_clo  = ms_ok && (mes_w == 3'h2 || mes_w == 3'h6 ||
                                mes_w == 3'h7);
  wire logic d_res  = ms_ok && (mes_w == 3'h3 || mes_w == 3'h6);
  wire logic d_clo  = ms_ok && (mes_w == 3'h4 || mes_w == 3'h5 ||
                                mes_w == 3'h7);

  // squitter, antenna and position command strobes
  wire logic rc_new  = d_ext && rcs_w != 3'h0 &&
                       rcs_w <= msd_pkg::RC_SUP120;
  wire logic sa_new  = d_ext;
  wire logic tc_new  = d_ext && tcs_w != 3'h0 &&
                       tcs_w <= msd_pkg::TC_CAN;
  wire logic [6:0] rc_load = (rcs_w == msd_pkg::RC_SUP120) ? S120 : S60;

  // reservation status readout for the utility field
  wire logic [5:0] um_w =
    (rss_w == 2'h1) ? {4'h1, 1'b0, commb_reserved} :
    (rss_w == 2'h2) ? {4'h2, 1'b0, commc_reserved} :
    (rss_w == 2'h3) ? {4'h3, 1'b0, commd_reserved} :
    msd_pkg::UM_RST;

  // one-second prescaler
  logic [PW-1:0] pre_r;
  logic          tick_r;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst || pre_r == PW'(CLK_HZ - 1))
      pre_r <= '0;
    else
      pre_r <= pre_r + 1'b1;
    tick_r <= !sys_rst && pre_r == PW'(CLK_HZ - 1);
  end

  // second timers; command restarts, expiry reverts
  logic [6:0] rc_t_r, sa_t_r, tc_t_r;
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      rc_t_r <= '0;
      sa_t_r <= '0;
      tc_t_r <= '0;
      squitter_rate <= msd_pkg::MSD_SQ_NORM;
      surface_antenna <= msd_pkg::MSD_ANT_TOP;
      surface_position <= 1'b0;
    end
    else
    begin
      if (rc_new)
      begin
        rc_t_r <= rc_load;
        case (rcs_w)
          msd_pkg::RC_HIGH: squitter_rate <= msd_pkg::MSD_SQ_HIGH;
          msd_pkg::RC_LOW:  squitter_rate <= msd_pkg::MSD_SQ_LOW;
          default:          squitter_rate <= msd_pkg::MSD_SQ_OFF;
        endcase
      end
      else if (tick_r && rc_t_r != 7'h00)
      begin
        rc_t_r <= rc_t_r - 7'h01;
        if (rc_t_r == 7'h01)
          squitter_rate <= msd_pkg::MSD_SQ_NORM;
      end
      if (sa_new)
      begin
        case (sas_w)
          msd_pkg::SA_ALT:
          begin
            surface_antenna <= msd_pkg::MSD_ANT_ALT;
            sa_t_r <= S120;
          end
          msd_pkg::SA_BOT:
          begin
            surface_antenna <= msd_pkg::MSD_ANT_BOT;
            sa_t_r <= S120;
          end
          default:
          begin
            surface_antenna <= msd_pkg::MSD_ANT_TOP;
            sa_t_r <= '0;
          end
        endcase
      end
      else if (tick_r && sa_t_r != 7'h00)
      begin
        sa_t_r <= sa_t_r - 7'h01;
        if (sa_t_r == 7'h01)
          surface_antenna <= msd_pkg::MSD_ANT_TOP;
      end
      if (tc_new)
      begin
        surface_position <= tcs_w != msd_pkg::TC_CAN;
        case (tcs_w)
          msd_pkg::TC_S15: tc_t_r <= S15;
          msd_pkg::TC_S60: tc_t_r <= S60;
          default:         tc_t_r <= '0;
        endcase
      end
      else if (tick_r && tc_t_r != 7'h00)
      begin
        tc_t_r <= tc_t_r - 7'h01;
        if (tc_t_r == 7'h01)
          surface_position <= 1'b0;
      end
    end
  end

  // lockout tables indexed by interrogator code
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      allcall_lockout <= '0;
      surv_lockout <= '0;
    end
    else
    begin
      if (lock_ac)
        allcall_lockout[iis_w] <= 1'b1;
      if (lock_sv)
        surv_lockout[sis_w] <= 1'b1;
    end
  end

  // field and command outputs, registered per accepted frame; uplink_format on every valid frame
  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
    begin
      uplink_format <= '0;
      sd_valid <= 1'b0;
      special_designator_field <= '0;
      designator_identifier <= '0;
      interrogator_id_subfield <= '0;
      surveillance_identifier_subfield <= '0;
      allcall_lock_pulse <= 1'b0;
      surv_lock_pulse <= 1'b0;
      commb_multisite_command <= '0;
      elm_multisite_command <= '0;
      {commb_reserve, commb_close} <= 2'h0;
      {commc_reserve, commc_close, commd_reserve, commd_close} <= 4'h0;
      bds2_code <= msd_pkg::BDS2_DEF;
      reservation_status_query <= '0;
      utility_message_field <= msd_pkg::UM_RST;
    end
    else
    begin
      sd_valid <= go;
      allcall_lock_pulse <= lock_ac;
      surv_lock_pulse <= lock_sv;
      {commb_reserve, commb_close} <= {mb_res, mb_clo};
      {commc_reserve, commc_close, commd_reserve, commd_close} <=
        {c_res, c_clo, d_res, d_clo};
      if (frame_valid)
        uplink_format <= uf_w;
      if (go)
      begin
        special_designator_field <= sd_w;
        designator_identifier <= di_w;
        interrogator_id_subfield <= di_iis ? iis_w : 4'h0;
        surveillance_identifier_subfield <= d_surv ? sis_w : 6'h00;
        commb_multisite_command <= d_multi ? mbs_w : 2'h0;
        elm_multisite_command <= d_multi ? mes_w : 3'h0;
        bds2_code <= d_rreq ? rrs_w : msd_pkg::BDS2_DEF;
        reservation_status_query <= d_multi ? rss_w : 2'h0;
        utility_message_field <= d_multi ? um_w : msd_pkg::UM_RST;
      end
    end
  end
endmodule

// ===== hdl/msd_pkg.sv
package msd_pkg;
  // uplink frame geometry, bit 1 is the first bit on air (frame msb)
  localparam int UF_MSB     = 1;
  localparam int UF_W       = 5;
  localparam int SD_FIRST   = 17;
  localparam int SD_W       = 16;
  localparam logic [4:0] UF_SURV_ALT  = 5'h04;
  localparam logic [4:0] UF_SURV_ID   = 5'h05;
  localparam logic [4:0] UF_COMMA_ALT = 5'h14;
  localparam logic [4:0] UF_COMMA_ID  = 5'h15;
  localparam logic [4:0] UF_ALLCALL   = 5'h0B;
  // designator identifier positions and codes
  localparam int DI_FIRST = 14;
  localparam int DI_W     = 3;
  localparam logic [2:0] DI_IIS0 = 3'h0;
  localparam logic [2:0] DI_MULTI = 3'h1;
  localparam logic [2:0] DI_EXT   = 3'h2;
  localparam logic [2:0] DI_SURV  = 3'h3;
  localparam logic [2:0] DI_RREQ  = 3'h7;
  // subfield positions (first bit, frame numbering)
  localparam int IIS_POS  = 17;
  localparam int MBS_POS  = 21;
  localparam int MES_POS  = 23;
  localparam int LSS_POS  = 23;
  localparam int LOS_POS  = 26;
  localparam int RCS_POS  = 24;
  localparam int RRS_POS  = 21;
  localparam int RSS_POS  = 27;
  localparam int SAS_POS  = 27;
  localparam int SIS_POS  = 17;
  localparam int TCS_POS  = 21;
  // command timers, in seconds; reference clock rate, in Hz
  localparam int T60_S    = 60;
  localparam int T120_S   = 120;
  localparam int T15_S    = 15;
  localparam int CLK_HZ   = 25000000;
  // command codes
  localparam logic [1:0] MB_RES = 2'h1;
  localparam logic [1:0] MB_CLO = 2'h2;
  localparam logic [2:0] RC_HIGH = 3'h1;
  localparam logic [2:0] RC_LOW  = 3'h2;
  localparam logic [2:0] RC_SUP60  = 3'h3;
  localparam logic [2:0] RC_SUP120 = 3'h4;
  localparam logic [1:0] SA_ALT  = 2'h1;
  localparam logic [1:0] SA_BOT  = 2'h2;
  localparam logic [2:0] TC_S15  = 3'h1;
  localparam logic [2:0] TC_S60  = 3'h2;
  localparam logic [2:0] TC_CAN  = 3'h3;
  localparam logic [3:0] BDS2_DEF = 4'h0;
  localparam logic [5:0] UM_RST   = 6'h00;
  typedef enum logic [1:0] {MSD_SQ_NORM, MSD_SQ_HIGH, MSD_SQ_LOW,
                            MSD_SQ_OFF} msd_rate_t;
  typedef enum logic [1:0] {MSD_ANT_TOP, MSD_ANT_ALT,
                            MSD_ANT_BOT} msd_ant_t;
endpackage

// ===== sim/msd_chk.sv
`timescale 1ns/1ps
// decoder port checker: relations between uplink frames and outputs
module msd_chk (
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire logic        frame_valid,
  input wire logic [55:0] frame_bits,
  input wire logic [4:0]  uplink_format,
  input wire logic        sd_valid,
  input wire logic [15:0] special_designator_field,
  input wire logic [5:0]  surveillance_identifier_subfield,
  input wire logic [15:0] allcall_lockout,
  input wire logic        allcall_lock_pulse,
  input wire logic        commb_reserve,
  input wire logic [3:0]  bds2_code,
  input wire logic [1:0]  squitter_rate,
  input wire logic [1:0]  surface_antenna
);
  logic [55:0] f_q;
  logic        t_q;
  wire  [4:0]  uf_w = frame_bits[55:51];
  wire         sdf_w = frame_valid && (uf_w inside {5'h04, 5'h05, 5'h14, 5'h15});
  wire  [2:0]  di_w = f_q[42:40];
  wire  [3:0]  ii_w = f_q[39:36];
  // remember the frame taken at the last edge
  always_ff @(posedge ref_clk)
  begin
    f_q <= frame_bits;
    t_q <= sdf_w && !sys_rst;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  a_sd_strobe: assert property (sd_valid == t_q)
    else $error("sd_valid does not follow a designator frame");
  a_sd_capture: assert property (t_q |-> special_designator_field == f_q[39:24])
    else $error("designator field not bits 17 to 32");
  a_format_any: assert property (!$past(sys_rst) && $past(frame_valid)
    |-> uplink_format == f_q[55:51])
    else $error("uplink format not first five bits");
  a_sis_field: assert property (t_q |-> surveillance_identifier_subfield
    == (di_w == 3'h3 ? f_q[39:34] : 6'h00))
    else $error("surveillance id wrong");
  a_allcall_lock: assert property (t_q && (di_w inside {3'h1, 3'h7}) && f_q[30]
    && ii_w != 4'h0 |-> allcall_lock_pulse && allcall_lockout[ii_w])
    else $error("all-call lockout not applied");
  a_id_zero: assert property (t_q && ii_w == 4'h0
    |-> !allcall_lock_pulse && !commb_reserve)
    else $error("action taken for id zero");
  a_commb_res: assert property (t_q |-> commb_reserve == (di_w == 3'h1
    && ii_w != 4'h0 && f_q[35:34] == 2'h1))
    else $error("comm-b reservation wrong");
  a_bds2_sel: assert property (t_q
    |-> bds2_code == (di_w == 3'h7 ? f_q[35:32] : 4'h0))
    else $error("bds2 code wrong");
  a_rate_load: assert property (t_q && di_w == 3'h2 && (f_q[32:30] inside {[1:4]})
    |-> squitter_rate == (f_q[32] ? 2'h3 : f_q[31:30]))
    else $error("squitter rate not loaded");
  a_ant_load: assert property (t_q && di_w == 3'h2 |-> surface_antenna
    == ((f_q[29:28] inside {2'h1, 2'h2}) ? f_q[29:28] : 2'h0))
    else $error("antenna command wrong");
  a_lock_sticky: assert property (!$past(sys_rst) |-> (allcall_lockout
    & $past(allcall_lockout)) == $past(allcall_lockout))
    else $error("all-call lockout entry dropped");
endmodule
bind msd_decoder msd_chk msd_chk_i (.*);

// ===== sim/msd_interrogator.sv
`timescale 1ns/1ps
// ground interrogator model: forms uplink frames, caller owns timing
module msd_interrogator (
  output logic        frame_valid,
  output logic [55:0] frame_bits
);
  initial
  begin
    frame_valid = 1'b0;
    frame_bits  = 56'h00000000000000;
  end
  // format first, designator at 14-16, field at 17-32, filler random
  task automatic drive(input logic [4:0] uf, input logic [2:0] di,
                       input logic [15:0] sd);
    logic [31:0] r;
    r = $urandom;
    frame_valid = 1'b1;
    frame_bits  = {uf, r[31:24], di, sd, r[23:0]};
  endtask
  // released line shows a toggled pattern
  task automatic release_line();
    frame_valid = 1'b0;
    frame_bits  = ~frame_bits;
  endtask
endmodule

// ===== sim/mode_s_sd_subfield_decoder_test.sv
`timescale 1ns/1ps
module mode_s_sd_subfield_decoder_test;
  localparam int HZ = 10;
  localparam logic [4:0]  UFS [4] = '{5'h04, 5'h05, 5'h14, 5'h15};
  localparam logic [15:0] TS [6] = '{16'h0040, 16'h0100, 16'h0010,
                                     16'h0020, 16'h0200, 16'h0400};
  localparam logic [4:0]  TV [6] = '{5'h08, 5'h18, 5'h02, 5'h04, 5'h01, 5'h01};
  localparam int          TN [6] = '{60, 120, 120, 120, 15, 60};
  logic        ref_clk, sys_rst, frame_valid, sd_valid, surface_position;
  logic        commb_reserved, commc_reserved, commd_reserved;
  logic        allcall_lock_pulse, surv_lock_pulse, commb_reserve;
  logic        commb_close, commc_reserve, commc_close;
  logic        commd_reserve, commd_close;
  logic [55:0] frame_bits;
  logic [4:0]  uplink_format;
  logic [15:0] special_designator_field, allcall_lockout, exp_al;
  logic [2:0]  designator_identifier, elm_multisite_command;
  logic [3:0]  interrogator_id_subfield, bds2_code;
  logic [5:0]  surveillance_identifier_subfield, utility_message_field;
  logic [63:0] surv_lockout, exp_sv;
  logic [1:0]  commb_multisite_command, reservation_status_query;
  logic [1:0]  squitter_rate, surface_antenna;
  int          err_total, samples_checked;
  logic [53:0] notes [$];
  msd_decoder #(.CLK_HZ(HZ)) msd_decoder_i (.*);
  msd_interrogator msd_interrogator_i (.*);
  // clock, 40 ns period
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic check(input string nm, input logic [63:0] got, exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // expected field outputs and pulses for one frame
  function automatic logic [53:0] ex(logic [2:0] di, logic [15:0] s,
                                     logic [2:0] rv);
    logic m, d3, ok;
    logic [3:0] i;
    logic [5:0] si;
    logic [2:0] e;
    logic [1:0] q, b;
    m = di == 3'h1;
    d3 = di == 3'h3;
    i = (di == 3'h0 || m || di == 3'h7) ? s[15:12] : 4'h0;
    si = d3 ? s[15:10] : 6'h00;
    e = m ? s[9:7] : 3'h0;
    q = m ? s[5:4] : 2'h0;
    b = m ? s[11:10] : 2'h0;
    ok = m && i != 4'h0;
    return {di, i, si, b, e, di == 3'h7 ? s[11:8] : 4'h0, q,
      q == 2'h0 ? 6'h00 : {2'h0, q, 1'b0, rv[2'h3 - q]}, s,
      (m || di == 3'h7) && s[6] && i != 4'h0, d3 && s[9] && si != 6'h00,
      ok && b == 2'h1, ok && b == 2'h2, ok && (e inside {3'h1, 3'h5}),
      ok && (e inside {3'h2, 3'h6, 3'h7}), ok && (e inside {3'h3, 3'h6}),
      ok && (e inside {3'h4, 3'h5, 3'h7})};
  endfunction
  // one frame after the next edge; note the expected result
  task automatic fr(input logic [4:0] uf, input logic [2:0] di,
                    input logic [15:0] s, input logic [2:0] rv);
    logic [53:0] e;
    e = ex(di, s, rv);
    @(posedge ref_clk);
    #1;
    {commb_reserved, commc_reserved, commd_reserved} = rv;
    msd_interrogator_i.drive(uf, di, s);
    if (uf inside {5'h04, 5'h05, 5'h14, 5'h15})
    begin
      notes.push_back(e);
      exp_al[e[50:47]] = exp_al[e[50:47]] | e[7];
      exp_sv[e[46:41]] = exp_sv[e[46:41]] | e[6];
    end
  endtask
  task automatic idle();
    @(posedge ref_clk);
    #1;
    msd_interrogator_i.release_line();
  endtask
  // result watcher: oldest note against each decoded result
  always @(posedge ref_clk)
  begin
    #1;
    if (sd_valid === 1'b1)
    begin
      if (notes.size() == 0)
        check("unexpected result", 1, 0);
      else
        check("decoded fields", {designator_identifier,
          interrogator_id_subfield, surveillance_identifier_subfield,
          commb_multisite_command, elm_multisite_command, bds2_code,
          reservation_status_query, utility_message_field,
          special_designator_field, allcall_lock_pulse, surv_lock_pulse,
          commb_reserve, commb_close, commc_reserve, commc_close,
          commd_reserve, commd_close}, notes.pop_front());
    end
  end
  // hang guard
  initial
  begin
    #2000000;
    err_total++;
    $display("[ERR] run length expected finish seen hang");
    final_report();
  end
  initial
  begin
    sys_rst = 1'b1;
    {commb_reserved, commc_reserved, commd_reserved} = 3'h0;
    err_total = 0;
    samples_checked = 0;
    exp_al = '0;
    exp_sv = '0;
    void'($urandom(75));
    repeat (8) @(posedge ref_clk);
    #1;
    sys_rst = 1'b0;
    check("reset state", {uplink_format, allcall_lockout, squitter_rate,
      surface_antenna, surface_position, bds2_code}, 0);
    $display("test reset done");
    fr(5'h0B, 3'h1, 16'hFFFF, 3'h7);
    idle();
    check("other format", uplink_format, 5'h0B);
    $display("test other format done");
    for (int k = 0; k < 8; k++)
      fr(UFS[k % 4], 3'h1, {4'(k), 2'(k % 3), 3'(k), k[0], k[1:0], 4'h0},
         3'(k));
    idle();
    $display("test multisite codes done");
    for (int k = 0; k < 6; k++)
    begin
      fr(UFS[k % 4], 3'h2, TS[k], 3'h0);
      idle();
      repeat ((TN[k] - 1) * HZ - 2) @(posedge ref_clk);
      #1;
      check("timed level", {squitter_rate, surface_antenna, surface_position},
        TV[k]);
      repeat (2 * HZ + 4) @(posedge ref_clk);
      #1;
      check("timed revert", {squitter_rate, surface_antenna,
        surface_position}, 5'h00);
    end
    $display("test timers done");
    fr(5'h04, 3'h2, 16'h0040, 3'h0);
    idle();
    repeat (40 * HZ) @(posedge ref_clk);
    fr(5'h05, 3'h2, 16'h0140, 3'h0);
    fr(5'h14, 3'h2, 16'h0040, 3'h0);
    idle();
    repeat (58 * HZ) @(posedge ref_clk);
    #1;
    check("rate restarted", squitter_rate, 2'h1);
    fr(5'h15, 3'h2, 16'h0220, 3'h0);
    idle();
    check("type and antenna", {surface_antenna, surface_position}, 3'h5);
    fr(5'h04, 3'h2, 16'h0630, 3'h0);
    idle();
    check("cancel and default", {surface_antenna, surface_position}, 3'h0);
    $display("test restart and cancel done");
    for (int k = 0; k < 80; k++)
      fr(UFS[$urandom % 4], 3'($urandom), 16'($urandom), 3'($urandom));
    idle();
    repeat (3) @(posedge ref_clk);
    #1;
    check("results pending", notes.size(), 0);
    check("all-call lockouts", allcall_lockout, exp_al);
    check("surveillance lockouts", surv_lockout, exp_sv);
    $display("test random frames done");
    final_report();
  end
endmodule
